// ==== logic/exec_alu.sv ====
// combinational result and flag computation for the instruction subset
`timescale 1ns/10ps
`default_nettype none
module exec_alu
   import exec_subset_pkg::*;
(
   // operation and operands
   input  wire op_t               op,
   input  wire logic [DATA_W-1:0] accIn,
   input  wire logic [DATA_W-1:0] fileIn,
   input  wire logic [DATA_W-1:0] literalIn,
   input  wire logic              carryIn,
   // result and flags
   output logic [DATA_W-1:0]      result,
   output logic                   carryOut,
   output logic                   halfOut,
   output logic                   zeroOut,
   output logic                   carryWr,
   output logic                   halfWr,
   output logic                   zeroWr
);
   logic [DATA_W-1:0] minuend;
   logic [DATA_W:0]   diff;
   logic [4:0]        lowDiff;

   always_comb begin
      minuend  = (op == OP_LITERAL_MINUS_ACC) ? literalIn : fileIn;
      // borrow-free subtraction sets the carry out
      diff     = {1'b0, minuend} + {1'b0, ~accIn} + 9'h001;
      lowDiff  = {1'b0, minuend[3:0]} + {1'b0, ~accIn[3:0]} + 5'h01;
      result   = 8'h00;
      carryOut = carryIn;
      halfOut  = 1'b0;
      carryWr  = 1'b0;
      halfWr   = 1'b0;
      zeroWr   = 1'b0;
      case (op)
         OP_LITERAL_MINUS_ACC, OP_FILE_MINUS_ACC: begin
            result   = diff[DATA_W-1:0];
            carryOut = diff[DATA_W];
            halfOut  = lowDiff[4];
            carryWr  = 1'b1;
            halfWr   = 1'b1;
            zeroWr   = 1'b1;
         end
         OP_ROTATE_RIGHT_FILE: begin
            result   = {carryIn, fileIn[DATA_W-1:1]};
            carryOut = fileIn[0];
            carryWr  = 1'b1;
         end
         OP_NIBBLE_EXCHANGE: begin
            result = {fileIn[3:0], fileIn[7:4]};
         end
         OP_LITERAL_XOR_ACC: begin
            result = accIn ^ literalIn;
            zeroWr = 1'b1;
         end
         OP_FILE_XOR_ACC: begin
            result = accIn ^ fileIn;
            zeroWr = 1'b1;
         end
         default: begin
            result = accIn;
         end
      endcase
      zeroOut = (result == 8'h00);
   end
endmodule : exec_alu
`default_nettype wire

// ==== logic/exec_subset_pkg.sv ====
// shared constants and types for the instruction execution subset
package exec_subset_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int NUM_FILE = 128;
   localparam int WDT_W = 8;
   localparam int PRESC_W = 8;
   // destination select encodings
   localparam logic DEST_ACC = 1'b0;
   localparam logic DEST_FILE = 1'b1;
   // values after reset
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
   localparam logic [DATA_W-1:0] FILE_RST = 8'h00;
   localparam logic [WDT_W-1:0] WDT_CLR = 8'h00;
   localparam logic [PRESC_W-1:0] PRESC_CLR = 8'h00;
   localparam logic CARRY_RST = 1'b0;
   localparam logic HALF_RST = 1'b0;
   localparam logic ZERO_RST = 1'b0;
   localparam logic PD_FLAG_RST = 1'b1;
   localparam logic TO_FLAG_RST = 1'b1;

   typedef enum logic [2:0] {
      OP_NONE              = 3'h0,
      OP_POWER_DOWN        = 3'h1,
      OP_LITERAL_MINUS_ACC = 3'h2,
      OP_ROTATE_RIGHT_FILE = 3'h3,
      OP_FILE_MINUS_ACC    = 3'h4,
      OP_NIBBLE_EXCHANGE   = 3'h5,
      OP_LITERAL_XOR_ACC   = 3'h6,
      OP_FILE_XOR_ACC      = 3'h7
   } op_t;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b01,
      ST_SLEEP = 2'b10
   } core_state_t;
endpackage : exec_subset_pkg

// ==== logic/mcu_instruction_exec_subset.sv ====
// execution unit for a subset of an 8-bit core instruction set
// Notes on behaviour
// - power-down enters sleep, stops the oscillator, halts execution until wake-up
// - power-down clears watchdog counter and its prescaler
// - power-down clears power-down flag, sets watchdog-expiry flag, nothing else
// - literal minus acc into acc, updates carry, half-borrow, zero
// - rotate file right through carry; only carry changes
// - file minus acc to destination, updates carry, half-borrow, zero
// - nibble exchange swaps halves, flags unchanged
// - literal xor acc into acc, only zero changes
// - file xor acc to destination, only zero changes
// - destination 0 writes acc, 1 writes addressed file register; literal forms always write acc
`timescale 1ns/10ps
`default_nettype none
module mcu_instruction_exec_subset
   import exec_subset_pkg::*;
(
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // instruction issue
   input  wire logic              instrValid,
   input  wire op_t               instrOp,
   input  wire logic [DATA_W-1:0] literal,
   input  wire logic [ADDR_W-1:0] fileAddr,
   input  wire logic              destSel,
   // wake-up from outside logic
   input  wire logic              wakeUp,
   // watchdog tick from the prescaler source
   input  wire logic              wdtTick,
   // architectural state
   output logic [DATA_W-1:0]      acc,
   output logic                   carryFlag,
   output logic                   halfBorrowFlag,
   output logic                   zeroFlag,
   output logic                   powerDownFlagN,
   output logic                   watchdogExpiryFlagN,
   output logic [WDT_W-1:0]       watchdogTimer,
   output logic [PRESC_W-1:0]     watchdogPrescaler,
   output logic                   sleeping,
   output logic                   oscEnable
);
   logic [DATA_W-1:0]  acc_q, acc_d;
   logic [DATA_W-1:0]  file_q [NUM_FILE];
   logic [DATA_W-1:0]  file_d [NUM_FILE];
   logic               carry_q;
   logic               carry_d;
   logic               half_q;
   logic               half_d;
   logic               zero_q;
   logic               zero_d;
   logic               pdN_q;
   logic               pdN_d;
   logic               toN_q;
   logic               toN_d;
   logic [WDT_W-1:0]   wdt_q, wdt_d;
   logic [PRESC_W-1:0] presc_q, presc_d;
   core_state_t        state_q, state_d;
   logic               wakeS1_q;
   logic               wakeS2_q;
   logic               tickS1_q;
   logic               tickS2_q;

   logic [DATA_W-1:0]  aluResult;
   logic               aluCarry;
   logic               aluHalf;
   logic               aluZero;
   logic               carryWr;
   logic               halfWr;
   logic               zeroWr;
   logic               exec;
   logic [DATA_W-1:0]  fileRd;

   assign fileRd = file_q[fileAddr];
   assign exec   = instrValid && (state_q == ST_RUN);

   exec_alu u_alu (
      .op        (instrOp),
      .accIn     (acc_q),
      .fileIn    (fileRd),
      .literalIn (literal),
      .carryIn   (carry_q),
      .result    (aluResult),
      .carryOut  (aluCarry),
      .halfOut   (aluHalf),
      .zeroOut   (aluZero),
      .carryWr   (carryWr),
      .halfWr    (halfWr),
      .zeroWr    (zeroWr)
   );

   // pin inputs pass two flip-flops before use
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wakeS1_q <= 1'b0;
         wakeS2_q <= 1'b0;
         tickS1_q <= 1'b0;
         tickS2_q <= 1'b0;
      end else begin
         wakeS1_q <= wakeUp;
         wakeS2_q <= wakeS1_q;
         tickS1_q <= wdtTick;
         tickS2_q <= tickS1_q;
      end
   end

   // datapath and flags
   always_comb begin
      acc_d   = acc_q;
      carry_d = carry_q;
      half_d  = half_q;
      zero_d  = zero_q;
      for (int i = 0; i < NUM_FILE; i++) begin
         file_d[i] = file_q[i];
      end
      if (exec && instrOp != OP_POWER_DOWN && instrOp != OP_NONE) begin
         if (carryWr) begin
            carry_d = aluCarry;
         end
         if (halfWr) begin
            half_d = aluHalf;
         end
         if (zeroWr) begin
            zero_d = aluZero;
         end
         // literal forms always target the accumulator
         if (instrOp == OP_LITERAL_MINUS_ACC || instrOp == OP_LITERAL_XOR_ACC)
         begin
            acc_d = aluResult;
         end else if (destSel == DEST_ACC) begin
            acc_d = aluResult;
         end else begin
            file_d[fileAddr] = aluResult;
         end
      end
   end

   // sleep state, watchdog and power status
   always_comb begin
      state_d = state_q;
      pdN_d   = pdN_q;
      toN_d   = toN_q;
      wdt_d   = wdt_q;
      presc_d = presc_q;
      // prescaler counts ticks; the watchdog advances on prescaler wrap
      if (tickS2_q && state_q == ST_RUN) begin
         presc_d = presc_q + 8'h01;
         if (presc_q == 8'hFF) begin
            wdt_d = wdt_q + 8'h01;
         end
      end
      case (state_q)
         ST_RUN: begin
            if (exec && instrOp == OP_POWER_DOWN) begin
               state_d = ST_SLEEP;
               wdt_d   = WDT_CLR;
               presc_d = PRESC_CLR;
               pdN_d   = 1'b0;
               toN_d   = 1'b1;
            end
         end
         ST_SLEEP: begin
            if (wakeS2_q) begin
               state_d = ST_RUN;
            end
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         acc_q   <= ACC_RST;
         carry_q <= CARRY_RST;
         half_q  <= HALF_RST;
         zero_q  <= ZERO_RST;
         pdN_q   <= PD_FLAG_RST;
         toN_q   <= TO_FLAG_RST;
         wdt_q   <= WDT_CLR;
         presc_q <= PRESC_CLR;
         state_q <= ST_RUN;
         for (int i = 0; i < NUM_FILE; i++) begin
            file_q[i] <= FILE_RST;
         end
      end else begin
         acc_q   <= acc_d;
         carry_q <= carry_d;
         half_q  <= half_d;
         zero_q  <= zero_d;
         pdN_q   <= pdN_d;
         toN_q   <= toN_d;
         wdt_q   <= wdt_d;
         presc_q <= presc_d;
         state_q <= state_d;
         for (int i = 0; i < NUM_FILE; i++) begin
            file_q[i] <= file_d[i];
         end
      end
   end

   assign acc                 = acc_q;
   assign carryFlag           = carry_q;
   assign halfBorrowFlag      = half_q;
   assign zeroFlag            = zero_q;
   assign powerDownFlagN      = pdN_q;
   assign watchdogExpiryFlagN = toN_q;
   assign watchdogTimer       = wdt_q;
   assign watchdogPrescaler   = presc_q;
   // one-hot state bits drive the pins directly, no decode glitches
   assign sleeping            = state_q[1];
   assign oscEnable           = state_q[0];
endmodule : mcu_instruction_exec_subset
`default_nettype wire

// ==== verification/mcu_instruction_exec_subset_asserts.sv ====
// concurrent checks for the instruction execution subset
`timescale 1ns/10ps
`default_nettype none
module mcu_instruction_exec_subset_asserts
   import exec_subset_pkg::*;
(
   // clock and reset
   input wire logic               sys_clk,
   input wire logic               rst,
   // instruction issue
   input wire logic               instrValid,
   input wire op_t                instrOp,
   input wire logic [DATA_W-1:0]  literal,
   input wire logic               destSel,
   // architectural state
   input wire logic [DATA_W-1:0]  acc,
   input wire logic               carryFlag,
   input wire logic               halfBorrowFlag,
   input wire logic               zeroFlag,
   input wire logic               powerDownFlagN,
   input wire logic               watchdogExpiryFlagN,
   input wire logic [WDT_W-1:0]   watchdogTimer,
   input wire logic [PRESC_W-1:0] watchdogPrescaler,
   input wire logic               sleeping,
   input wire logic               oscEnable
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic              run;
   logic              pdGo;
   logic [DATA_W-1:0] litSub;
   logic [DATA_W-1:0] litXor;
   logic              litGe;
   assign run = instrValid && !sleeping;
   assign pdGo = run && instrOp == OP_POWER_DOWN;
   assign litSub = literal - acc;
   assign litXor = literal ^ acc;
   assign litGe = literal >= acc;
   property p_sleep; pdGo |=> sleeping && !oscEnable; endproperty
   property p_wdog;
      pdGo |=> watchdogTimer == WDT_CLR && watchdogPrescaler == PRESC_CLR;
   endproperty
   property p_pflag; pdGo |=> !powerDownFlagN && watchdogExpiryFlagN
      && $stable(zeroFlag) && $stable(carryFlag); endproperty
   property p_halt; sleeping |=> $stable(acc) && $stable(zeroFlag);
   endproperty
   property p_sub; run && instrOp == OP_LITERAL_MINUS_ACC |=> acc ==
      $past(litSub) && carryFlag == $past(litGe) && zeroFlag == !acc;
   endproperty
   property p_xor; run && instrOp == OP_LITERAL_XOR_ACC |=> acc ==
      $past(litXor) && $stable(carryFlag) && $stable(halfBorrowFlag);
   endproperty
   property p_swap; run && instrOp == OP_NIBBLE_EXCHANGE
      |=> $stable({carryFlag, halfBorrowFlag, zeroFlag}); endproperty
   property p_rot; run && instrOp == OP_ROTATE_RIGHT_FILE && !destSel
      |=> acc[7] == $past(carryFlag) && $stable(zeroFlag); endproperty
   property p_dest; run && instrOp == OP_FILE_MINUS_ACC && destSel
      |=> $stable(acc); endproperty
   a_sleep: assert property (p_sleep) else $error("no sleep");
   a_wdog: assert property (p_wdog) else $error("wdog kept");
   a_pflag: assert property (p_pflag) else $error("pd flags");
   a_halt: assert property (p_halt) else $error("ran asleep");
   a_sub: assert property (p_sub) else $error("lit sub");
   a_xor: assert property (p_xor) else $error("lit xor");
   a_swap: assert property (p_swap) else $error("swap flags");
   a_rot: assert property (p_rot) else $error("rotate");
   a_dest: assert property (p_dest) else $error("file dest");
   c_pd: cover property (pdGo);
   c_wake: cover property (sleeping ##1 !sleeping);
   c_zero: cover property (run && instrOp == OP_FILE_MINUS_ACC ##1 zeroFlag);
endmodule : mcu_instruction_exec_subset_asserts
bind mcu_instruction_exec_subset mcu_instruction_exec_subset_asserts u_chk (
   .sys_clk, .rst, .instrValid, .instrOp, .literal, .destSel, .acc,
   .carryFlag, .halfBorrowFlag, .zeroFlag, .powerDownFlagN,
   .watchdogExpiryFlagN, .watchdogTimer, .watchdogPrescaler, .sleeping,
   .oscEnable);
`default_nettype wire

// ==== verification/mcu_instruction_exec_subset_tb.sv ====
// self-checking bench for the instruction execution subset
`timescale 1ns/10ps
`default_nettype none
module mcu_instruction_exec_subset_tb
   import exec_subset_pkg::*;
;
   logic sys_clk = 1'b0, rst = 1'b1, instrValid = 1'b0, destSel = 1'b0;
   logic wakeUp = 1'b0, wdtTick = 1'b0;
   op_t instrOp = OP_NONE;
   logic [DATA_W-1:0] literal = 8'h00, acc, eAcc, eF [NUM_FILE];
   logic [ADDR_W-1:0] fileAddr = 7'h00;
   logic carryFlag, halfBorrowFlag, zeroFlag, powerDownFlagN, sleeping;
   logic watchdogExpiryFlagN, oscEnable, eC, eH, eZ, eSlp, ePd, eTo;
   logic [WDT_W-1:0] watchdogTimer;
   logic [PRESC_W-1:0] watchdogPrescaler;
   int n_mismatch = 0, n_compared = 0, cyc = 0;
   localparam logic [7:0] SUB_K [6] = '{8'h3C, 8'h00, 8'h0F, 8'h10, 8'hFF,
                                         8'h00};
   mcu_instruction_exec_subset DUT (.sys_clk, .rst, .instrValid, .instrOp,
      .literal, .fileAddr, .destSel, .wakeUp, .wdtTick, .acc, .carryFlag,
      .halfBorrowFlag, .zeroFlag, .powerDownFlagN, .watchdogExpiryFlagN,
      .watchdogTimer, .watchdogPrescaler, .sleeping, .oscEnable);
   initial forever #2.5 sys_clk = ~sys_clk;
   // ticks toggle so both level and edge counting see activity
   always @(posedge sys_clk) wdtTick <= #1 ~wdtTick;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic do_reset();
      instrValid = 1'b0;
      rst = 1'b1;
      {eAcc, eC, eH, eZ} = {ACC_RST, CARRY_RST, HALF_RST, ZERO_RST};
      {eSlp, ePd, eTo} = {1'b0, PD_FLAG_RST, TO_FLAG_RST};
      foreach (eF[i]) eF[i] = FILE_RST;
      repeat (2) @(posedge sys_clk);
      #1 rst = 1'b0;
   endtask : do_reset
   // reference model of one instruction, then issue and compare
   task automatic exec(op_t op, logic [7:0] k, logic [6:0] a, logic d);
      logic [7:0] f, r, x;
      f = eF[a];
      r = eAcc;
      x = (op == OP_FILE_MINUS_ACC) ? f : k;
      if (!eSlp) begin
         case (op)
            OP_POWER_DOWN: {eSlp, ePd, eTo} = 3'b101;
            OP_LITERAL_MINUS_ACC, OP_FILE_MINUS_ACC: begin
               r = x - eAcc;
               eC = x >= eAcc;
               eH = x[3:0] >= eAcc[3:0];
            end
            OP_ROTATE_RIGHT_FILE: {r, eC} = {eC, f};
            OP_NIBBLE_EXCHANGE: r = {f[3:0], f[7:4]};
            OP_LITERAL_XOR_ACC: r = k ^ eAcc;
            OP_FILE_XOR_ACC: r = f ^ eAcc;
            default: ;
         endcase
         if (op inside {OP_LITERAL_MINUS_ACC, OP_FILE_MINUS_ACC,
                        OP_LITERAL_XOR_ACC, OP_FILE_XOR_ACC})
            eZ = (r == 8'h00);
         if (d && op inside {OP_ROTATE_RIGHT_FILE, OP_FILE_MINUS_ACC,
                             OP_NIBBLE_EXCHANGE, OP_FILE_XOR_ACC})
            eF[a] = r;
         else
            eAcc = r;
      end
      {instrValid, instrOp, literal, fileAddr, destSel} = {1'b1, op, k, a, d};
      @(posedge sys_clk);
      #1;
      chk(acc, eAcc);
      chk({5'h00, carryFlag, halfBorrowFlag, zeroFlag}, {5'h00, eC, eH, eZ});
      chk({4'h0, sleeping, oscEnable, powerDownFlagN, watchdogExpiryFlagN},
          {4'h0, eSlp, !eSlp, ePd, eTo});
   endtask : exec
   task automatic wake();
      instrValid = 1'b0;
      wakeUp = 1'b1;
      @(posedge sys_clk);
      #1 wakeUp = 1'b0;
      for (int i = 0; i < 10 && sleeping !== 1'b0; i++) begin
         @(posedge sys_clk);
         #1;
      end
      eSlp = 1'b0;
   endtask : wake
   initial begin
      do_reset();
      exec(OP_LITERAL_XOR_ACC, 8'hFF, 7'h00, DEST_ACC);
      exec(OP_FILE_XOR_ACC, 8'h00, 7'h05, DEST_FILE);
      exec(OP_LITERAL_XOR_ACC, 8'hC3, 7'h00, DEST_FILE);
      exec(OP_FILE_XOR_ACC, 8'h00, 7'h7F, DEST_FILE);
      exec(OP_FILE_XOR_ACC, 8'h00, 7'h7F, DEST_ACC);
      exec(OP_NIBBLE_EXCHANGE, 8'h00, 7'h7F, DEST_ACC);
      exec(OP_NIBBLE_EXCHANGE, 8'h00, 7'h7F, DEST_FILE);
      exec(OP_NIBBLE_EXCHANGE, 8'h00, 7'h7F, DEST_ACC);
      foreach (SUB_K[i]) exec(OP_LITERAL_MINUS_ACC, SUB_K[i], 7'h00, 1'b0);
      exec(OP_FILE_MINUS_ACC, 8'h00, 7'h05, DEST_FILE);
      exec(OP_FILE_MINUS_ACC, 8'h00, 7'h05, DEST_ACC);
      exec(OP_ROTATE_RIGHT_FILE, 8'h00, 7'h05, DEST_FILE);
      exec(OP_ROTATE_RIGHT_FILE, 8'h00, 7'h05, DEST_FILE);
      exec(OP_ROTATE_RIGHT_FILE, 8'h00, 7'h05, DEST_ACC);
      chk({7'h00, watchdogPrescaler != PRESC_CLR}, 8'h01);
      exec(OP_POWER_DOWN, 8'h00, 7'h00, DEST_ACC);
      chk({watchdogTimer}, WDT_CLR);
      chk({watchdogPrescaler}, PRESC_CLR);
      exec(OP_LITERAL_XOR_ACC, 8'h55, 7'h00, DEST_ACC);
      wake();
      exec(OP_LITERAL_XOR_ACC, 8'h55, 7'h00, DEST_ACC);
      do_reset();
      exec(OP_NONE, 8'h00, 7'h00, DEST_ACC);
      tally_and_finish();
   end
endmodule : mcu_instruction_exec_subset_tb
`default_nettype wire
